// [rtl/acwd_cal.sv]
// Purpose: calibration sequencer and coefficient storage
// Assumes: meas_in valid pulses once per modulator conversion
// Notes:   coefficients of the selected channel are read from flops
`timescale 1ns/1ns
module acwd_cal (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire acwd_pkg::acwd_mode_t mode_in,
  input  wire logic                channel_in,
  input  wire logic                power_down_in,
  input  wire acwd_pkg::acwd_meas_t meas_in,
  input  wire acwd_pkg::acwd_cwr_t  cwr_in,
  output logic [23:0]              zs_out,
  output logic [23:0]              fs_out,
  output logic [23:0]              result_out,
  output logic                     result_valid_out,
  output logic                     cal_done_out
);
  import acwd_pkg::*;

  typedef struct packed {
    logic [1:0][23:0] zs;
    logic [1:0][23:0] fs;
    logic [2:0]       bg_cnt;
    logic [23:0]      result;
    logic             result_valid;
    logic             cal_done;
  } acwd_cal_t;

  acwd_cal_t c_reg;
  acwd_cal_t c_next;

  // ==========================================================
  // sequencing
  always_comb begin
    c_next = c_reg;
    c_next.result_valid = 1'b0;
    c_next.cal_done = 1'b0;
    if (meas_in.valid && !power_down_in) begin
      case (mode_in)
        MODE_NORMAL: begin
          c_next.result = meas_in.conv_word;
          c_next.result_valid = 1'b1;
        end
        MODE_SELF: begin
          c_next.zs[channel_in] = meas_in.zero_word;
          c_next.fs[channel_in] = meas_in.ref_word;
          c_next.cal_done = 1'b1;
        end
        MODE_SYS_ZERO: begin
          c_next.zs[channel_in] = meas_in.conv_word;
          c_next.cal_done = 1'b1;
        end
        MODE_SYS_FULL: begin
          c_next.fs[channel_in] = meas_in.conv_word;
          c_next.cal_done = 1'b1;
        end
        MODE_SYS_OFFSET: begin
          c_next.zs[channel_in] = meas_in.conv_word;
          c_next.fs[channel_in] = meas_in.ref_word;
          c_next.cal_done = 1'b1;
        end
        MODE_BACKGROUND: begin
          c_next.zs[channel_in] = meas_in.zero_word;
          c_next.fs[channel_in] = meas_in.ref_word;
          if (c_reg.bg_cnt == BG_LAST) begin
            c_next.bg_cnt = 3'h0;
            c_next.result = meas_in.conv_word;
            c_next.result_valid = 1'b1;
          end else begin
            c_next.bg_cnt = c_reg.bg_cnt + 3'h1;
          end
        end
        default: begin
          c_next.bg_cnt = c_reg.bg_cnt;
        end
      endcase
    end
    if (mode_in != MODE_BACKGROUND) begin
      c_next.bg_cnt = 3'h0;
    end
    // host write overrides an update in the same cycle
    if (cwr_in.en) begin
      if (cwr_in.full) begin
        c_next.fs[channel_in] = cwr_in.data;
      end else begin
        c_next.zs[channel_in] = cwr_in.data;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      c_reg <= '0;
      c_reg.zs <= {ZS_RESET, ZS_RESET};
      c_reg.fs <= {FS_RESET, FS_RESET};
    end else if (ce_in) begin
      c_reg <= c_next;
    end
  end

  assign zs_out = c_reg.zs[channel_in];
  assign fs_out = c_reg.fs[channel_in];
  assign result_out = c_reg.result;
  assign result_valid_out = c_reg.result_valid;
  assign cal_done_out = c_reg.cal_done;

endmodule

// [rtl/acwd_pkg.sv]
// Purpose: shared types and constants of the control word decode block
// Assumes: 24-bit serial words, two analog channels
// Notes:   control word field layout is the packed struct order, msb first
package acwd_pkg;

  // ==========================================================
  // sizes and counts
  localparam int        WORD_W     = 24;
  localparam logic[4:0] WORD_LEN   = 5'h18;
  localparam logic[4:0] SHORT_LEN  = 5'h10;
  localparam logic[2:0] BG_LAST    = 3'h5;
  localparam logic[11:0] FILTER_RESET = 12'h145;
  localparam logic[23:0] ZS_RESET  = 24'h000000;
  localparam logic[23:0] FS_RESET  = 24'h800000;

  // ==========================================================
  // mode field codes
  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'h0,
    MODE_SELF       = 3'h1,
    MODE_SYS_ZERO   = 3'h2,
    MODE_SYS_FULL   = 3'h3,
    MODE_SYS_OFFSET = 3'h4,
    MODE_BACKGROUND = 3'h5,
    MODE_ZS_ACCESS  = 3'h6,
    MODE_FS_ACCESS  = 3'h7
  } acwd_mode_t;

  // ==========================================================
  // control word, bit 23 first
  typedef struct packed {
    acwd_mode_t  mode;
    logic [2:0]  gain;
    logic        channel_select_bit;
    logic        power_down_bit;
    logic        output_word_length_bit;
    logic        comp_current_bit;
    logic        burn_out_current_bit;
    logic        unipolar_bit;
    logic [11:0] filter_code;
  } acwd_ctrl_t;

  localparam acwd_ctrl_t CTRL_RESET = '{
    mode: MODE_NORMAL, gain: 3'h0, channel_select_bit: 1'b0,
    power_down_bit: 1'b0, output_word_length_bit: 1'b0,
    comp_current_bit: 1'b0, burn_out_current_bit: 1'b0,
    unipolar_bit: 1'b0, filter_code: FILTER_RESET};

  // measurement from the modulator and filter
  typedef struct packed {
    logic        valid;
    logic [23:0] conv_word;
    logic [23:0] zero_word;
    logic [23:0] ref_word;
  } acwd_meas_t;

  // host coefficient write
  typedef struct packed {
    logic        en;
    logic        full;
    logic [23:0] data;
  } acwd_cwr_t;

endpackage

// [rtl/acwd_top.sv]
// Purpose: serial control word, coefficient and data access of the converter
// Assumes: host drives frames and serial clock; one frame at a time
// Notes:   link logic runs on the serial clock, the rest on sys_clk_in
`timescale 1ns/1ns

module acwd_top (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic                link_clk_in,
  input  wire logic                transmit_frame_n_in,
  input  wire logic                receive_frame_n_in,
  input  wire logic                register_select_pin_in,
  input  wire logic                sdata_in,
  output logic                     sdata_out,
  output logic                     sdata_oe_out,
  input  wire acwd_pkg::acwd_meas_t meas_in,
  output logic                     data_ready_n_out,
  output acwd_pkg::acwd_mode_t      mode_out,
  output logic [2:0]               gain_out,
  output logic                     channel_select_out,
  output logic                     power_down_out,
  output logic                     word_length_out,
  output logic                     comp_current_out,
  output logic                     burn_out_current_out,
  output logic                     unipolar_out,
  output logic [11:0]              filter_code_out
);
  import acwd_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [4:0]  cnt;
    logic [23:0] shift;
    logic [4:0]  len;
    logic        sdo;
    logic        oe;
  } acwd_frame_t;

  typedef struct packed {
    logic        wr_tgl;
    logic        wr_target;
    logic [23:0] wr_word;
    logic        rd_tgl;
    logic        rd_data;
  } acwd_hold_t;

  typedef struct packed {
    acwd_ctrl_t  ctrl;
    logic [1:0]  wr_sync;
    logic        wr_seen;
    logic [1:0]  rd_sync;
    logic        rd_seen;
    logic [1:0]  rs_sync;
    logic [1:0]  rfrm_sync;
    logic [23:0] read_word;
    logic        read_short;
    logic        read_data;
    logic [23:0] data_word;
    logic        data_ready_n_n;
  } acwd_sys_t;

  acwd_frame_t f_reg;
  acwd_frame_t f_next;
  acwd_hold_t  h_reg;
  acwd_hold_t  h_next;
  acwd_sys_t   s_reg;
  acwd_sys_t   s_next;

  logic        frame_idle;
  logic [23:0] zs_word;
  logic [23:0] fs_word;
  logic [23:0] result_word;
  logic        result_valid;
  logic        cal_done;
  acwd_cwr_t   cwr;

  assign frame_idle = transmit_frame_n_in & receive_frame_n_in;

  // ==========================================================
  // link side, serial clock domain
  always_comb begin
    f_next = f_reg;
    h_next = h_reg;
    if (!transmit_frame_n_in) begin
      if (f_reg.cnt < WORD_LEN) begin
        f_next.shift = {f_reg.shift[22:0], sdata_in};
        f_next.cnt = f_reg.cnt + 5'h1;
        // word taken only on the 24th bit
        if (f_reg.cnt == WORD_LEN - 5'h1) begin
          h_next.wr_word = {f_reg.shift[22:0], sdata_in};
          h_next.wr_target = register_select_pin_in;
          h_next.wr_tgl = ~h_reg.wr_tgl;
        end
      end
      // further pulses leave count and word alone
    end else if (!receive_frame_n_in) begin
      if (f_reg.cnt == 5'h0) begin
        // sys side holds the word still while a read frame runs
        f_next.shift = {s_reg.read_word[22:0], 1'b0};
        f_next.sdo = s_reg.read_word[23];
        f_next.oe = 1'b1;
        f_next.len = s_reg.read_short ? SHORT_LEN : WORD_LEN;
        f_next.cnt = 5'h1;
        h_next.rd_data = s_reg.read_data;
      end else if (f_reg.cnt < f_reg.len) begin
        f_next.sdo = f_reg.shift[23];
        f_next.shift = {f_reg.shift[22:0], 1'b0};
        f_next.cnt = f_reg.cnt + 5'h1;
      end else if (f_reg.oe) begin
        f_next.oe = 1'b0;
        f_next.sdo = 1'b0;
        h_next.rd_tgl = ~h_reg.rd_tgl;
      end
    end
  end

  // frame counters clear while no frame is open
  always_ff @(posedge link_clk_in or posedge frame_idle) begin
    if (frame_idle) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign sdata_out = f_reg.sdo;
  assign sdata_oe_out = f_reg.oe;

  // ==========================================================
  // calibration and coefficients
  acwd_cal u_cal (
    .sys_clk_in       (sys_clk_in),
    .rst_in           (rst_in),
    .ce_in            (ce_in),
    .mode_in          (s_reg.ctrl.mode),
    .channel_in       (s_reg.ctrl.channel_select_bit),
    .power_down_in    (s_reg.ctrl.power_down_bit),
    .meas_in          (meas_in),
    .cwr_in           (cwr),
    .zs_out           (zs_word),
    .fs_out           (fs_word),
    .result_out       (result_word),
    .result_valid_out (result_valid),
    .cal_done_out     (cal_done)
  );

  // ==========================================================
  // system side decode
  always_comb begin
    s_next = s_reg;
    cwr = '0;
    s_next.wr_sync = {s_reg.wr_sync[0], h_reg.wr_tgl};
    s_next.rd_sync = {s_reg.rd_sync[0], h_reg.rd_tgl};
    s_next.rs_sync = {s_reg.rs_sync[0], register_select_pin_in};
    s_next.rfrm_sync = {s_reg.rfrm_sync[0], receive_frame_n_in};

    if (cal_done) begin
      s_next.ctrl.mode = MODE_NORMAL;
    end

    // completed 24-bit write frame
    if (s_reg.wr_sync[1] != s_reg.wr_seen) begin
      s_next.wr_seen = s_reg.wr_sync[1];
      if (!h_reg.wr_target) begin
        s_next.ctrl = h_reg.wr_word;
      end else if (s_reg.ctrl.mode == MODE_ZS_ACCESS) begin
        cwr.en = 1'b1;
        cwr.full = 1'b0;
        cwr.data = h_reg.wr_word;
      end else if (s_reg.ctrl.mode == MODE_FS_ACCESS) begin
        cwr.en = 1'b1;
        cwr.full = 1'b1;
        cwr.data = h_reg.wr_word;
      end
    end

    // finished read frame of the result releases data ready
    if (s_reg.rd_sync[1] != s_reg.rd_seen) begin
      s_next.rd_seen = s_reg.rd_sync[1];
      if (h_reg.rd_data) begin
        s_next.data_ready_n_n = 1'b1;
      end
    end
    // a new result wins over the release
    if (result_valid) begin
      s_next.data_word = result_word;
      s_next.data_ready_n_n = 1'b0;
    end
    if (cal_done) begin
      s_next.data_ready_n_n = 1'b0;
    end

    // read source, frozen while a read frame is open
    if (s_reg.rfrm_sync[1]) begin
      s_next.read_short = 1'b0;
      s_next.read_data = 1'b0;
      if (!s_reg.rs_sync[1]) begin
        s_next.read_word = s_reg.ctrl;
      end else if (s_reg.ctrl.mode == MODE_ZS_ACCESS) begin
        s_next.read_word = zs_word;
      end else if (s_reg.ctrl.mode == MODE_FS_ACCESS) begin
        s_next.read_word = fs_word;
      end else begin
        s_next.read_word = s_reg.data_word;
        s_next.read_short = ~s_reg.ctrl.output_word_length_bit;
        s_next.read_data = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.data_ready_n_n <= 1'b1;
      s_reg.rfrm_sync <= 2'h3;
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign data_ready_n_out = s_reg.data_ready_n_n;
  assign mode_out = s_reg.ctrl.mode;
  assign gain_out = s_reg.ctrl.gain;
  assign channel_select_out = s_reg.ctrl.channel_select_bit;
  assign power_down_out = s_reg.ctrl.power_down_bit;
  assign word_length_out = s_reg.ctrl.output_word_length_bit;
  assign comp_current_out = s_reg.ctrl.comp_current_bit;
  assign burn_out_current_out = s_reg.ctrl.burn_out_current_bit;
  assign unipolar_out = s_reg.ctrl.unipolar_bit;
  assign filter_code_out = s_reg.ctrl.filter_code;

endmodule

// [testbench/acwd_host.sv]
// Purpose: host side of the serial port
// Assumes: tasks start at a sys clock edge
// Notes:   link clock 64 ns, runs only inside frames
`timescale 1ns/1ns
module acwd_host (
  output logic      link_clk_out,
  output logic      tx_frame_n_out,
  output logic      rx_frame_n_out,
  output logic      sel_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  initial begin
    link_clk_out = 1'b0;
    tx_frame_n_out = 1'b1;
    rx_frame_n_out = 1'b0;
    sel_out = 1'b0;
    sdi_out = 1'b0;
    // frame edge at start clears the device's frame flops
    #1 rx_frame_n_out = 1'b1;
  end
  // ==========================================
  // frames; odd offset keeps edges off the sys edge
  task automatic write_word(input logic s, input logic [23:0] w, input int n);
    sel_out = s;
    #407;
    tx_frame_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = (i < 24) ? w[23-i] : ~sdi_out;
      #32 link_clk_out = 1'b1;
      #32 link_clk_out = 1'b0;
    end
    #32 tx_frame_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #600;
  endtask
  task automatic read_word(input logic s, input int n, output logic [23:0] w);
    w = 24'h0;
    sel_out = s;
    #407;
    rx_frame_n_out = 1'b0;
    #32;
    for (int i = 0; i <= n; i++) begin
      if (i > 0) w = {w[22:0], sdo_in};
      link_clk_out = 1'b1;
      #32 link_clk_out = 1'b0;
      #32;
    end
    rx_frame_n_out = 1'b1;
    #400;
  endtask
endmodule

// [testbench/acwd_properties.sv]
// Purpose: port assertions of acwd_top
// Assumes: sys_clk_in domain, read frame edges on link_clk_in
// Notes:   bound to acwd_top from tb
`timescale 1ns/1ns
module acwd_properties
  import acwd_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        ce_in,
  input wire logic        link_clk_in,
  input wire logic        transmit_frame_n_in,
  input wire logic        receive_frame_n_in,
  input wire logic        register_select_pin_in,
  input wire logic        sdata_oe_out,
  input wire acwd_meas_t  meas_in,
  input wire logic        data_ready_n_out,
  input wire acwd_mode_t  mode_out,
  input wire logic [2:0]  gain_out,
  input wire logic        channel_select_out,
  input wire logic        power_down_out,
  input wire logic        word_length_out,
  input wire logic        comp_current_out,
  input wire logic        burn_out_current_out,
  input wire logic        unipolar_out,
  input wire logic [11:0] filter_code_out
);
  // ==========================================
  // helpers
  logic [23:0] cw;
  logic [3:0]  idle;
  logic [4:0]  edges;
  logic        meas_ok;
  assign cw = {mode_out, gain_out, channel_select_out, power_down_out, word_length_out,
               comp_current_out, burn_out_current_out, unipolar_out, filter_code_out};
  assign meas_ok = meas_in.valid && ce_in && !power_down_out && idle > 4'h8;
  // sys cycles since the last write frame
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !transmit_frame_n_in) idle <= 4'h0;
    else if (idle != 4'hf) idle <= idle + 4'h1;
  end
  // link edges already seen in this read frame
  always_ff @(posedge link_clk_in or posedge receive_frame_n_in) begin
    if (receive_frame_n_in) edges <= 5'h0;
    else if (edges != 5'h1f) edges <= edges + 5'h1;
  end
  // ==========================================
  // assertions
  a_reset_word: assert property (@(posedge sys_clk_in) rst_in |=> cw == CTRL_RESET)
    else $error("control word not at default after reset");
  a_reset_ready: assert property (@(posedge sys_clk_in) rst_in |=> data_ready_n_out)
    else $error("data ready active after reset");
  a_idle_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    receive_frame_n_in |-> !sdata_oe_out) else $error("data driven outside read frame");
  a_oe_frame: assert property (@(posedge link_clk_in) disable iff (rst_in)
    (edges >= 5'h1 && (edges <= 5'h10 || (edges <= 5'h18 && (!register_select_pin_in
    || mode_out inside {MODE_ZS_ACCESS, MODE_FS_ACCESS})))) |-> sdata_oe_out)
    else $error("read word released too early");
  a_ready_new: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (mode_out == MODE_NORMAL && meas_ok) |-> ##2 !data_ready_n_out)
    else $error("no data ready after conversion");
  a_offset_done: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (mode_out == MODE_SYS_OFFSET && meas_ok) |-> ##2 (mode_out == MODE_NORMAL && !data_ready_n_out))
    else $error("offset calibration did not finish");
  a_pd_quiet: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (power_down_out && data_ready_n_out) [*3] |=> data_ready_n_out)
    else $error("result made in power-down");
  a_word_stable: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (idle == 4'hf && mode_out inside {MODE_NORMAL, MODE_BACKGROUND, MODE_ZS_ACCESS, MODE_FS_ACCESS})
    |=> $stable(cw)) else $error("control word changed without write");
  c_offset: cover property (@(posedge sys_clk_in) mode_out == MODE_SYS_OFFSET && meas_ok);
  c_bg_result: cover property (@(posedge sys_clk_in) mode_out == MODE_BACKGROUND && $fell(data_ready_n_out));
  c_coef_read: cover property (@(posedge link_clk_in) edges == 5'h18 && register_select_pin_in);
endmodule

// [testbench/tb.sv]
// Purpose: self-checking bench of acwd_top
// Assumes: host model drives the serial port
// Notes:   one task per scenario
`timescale 1ns/1ns
module tb;
  import acwd_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        link_clk_in, transmit_frame_n_in, receive_frame_n_in;
  logic        register_select_pin_in, sdata_in, sdata_out, sdata_oe_out;
  acwd_meas_t  meas_in = '0;
  logic        data_ready_n_out;
  acwd_mode_t  mode_out;
  logic [2:0]  gain_out;
  logic        channel_select_out, power_down_out, word_length_out;
  logic        comp_current_out, burn_out_current_out, unipolar_out;
  logic [11:0] filter_code_out;
  int          fail_count = 0;
  int          checks_done = 0;
  acwd_ctrl_t  cw;
  logic [23:0] rd;
  always #50 sys_clk_in = ~sys_clk_in;
  acwd_top acwd_top_i (.*);
  acwd_host acwd_host_i (.link_clk_out(link_clk_in), .tx_frame_n_out(transmit_frame_n_in),
    .rx_frame_n_out(receive_frame_n_in), .sel_out(register_select_pin_in), .sdi_out(sdata_in),
    .sdo_in(sdata_out));
  // ==========================================
  // shared tasks
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk_cw(input acwd_ctrl_t e);
    chk("ctrl", {mode_out, gain_out, channel_select_out, power_down_out, word_length_out,
      comp_current_out, burn_out_current_out, unipolar_out, filter_code_out}, e);
  endtask
  task automatic hw(input logic s, input logic [23:0] w, input int n);
    @(posedge sys_clk_in);
    acwd_host_i.write_word(s, w, n);
  endtask
  task automatic hr(input logic s, input int n);
    @(posedge sys_clk_in);
    acwd_host_i.read_word(s, n, rd);
  endtask
  task automatic wr_cw(input acwd_mode_t m, input logic c);
    cw.mode = m;
    cw.channel_select_bit = c;
    hw(1'b0, cw, 24);
  endtask
  task automatic pulse(input logic [23:0] c, input logic [23:0] z, input logic [23:0] r);
    @(posedge sys_clk_in);
    meas_in <= '{1'b1, c, z, r};
    @(posedge sys_clk_in);
    meas_in.valid <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 20 && data_ready_n_out !== 1'b0; i++) @(posedge sys_clk_in);
    chk("ready", 24'(data_ready_n_out), 24'h0);
    if (data_ready_n_out !== 1'b0) end_of_test();
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_fields;
    chk_cw(CTRL_RESET);
    for (int g = 0; g < 8; g++) begin
      cw = CTRL_RESET;
      cw.gain = 3'(g);
      {cw.channel_select_bit, cw.power_down_bit, cw.output_word_length_bit} = 3'(g);
      {cw.comp_current_bit, cw.burn_out_current_bit, cw.unipolar_bit} = 3'(~g);
      cw.filter_code = 12'h013 + 12'(g);
      hw(1'b0, cw, 24);
      chk_cw(cw);
    end
    hw(1'b0, ~cw, 12);
    chk_cw(cw);
    cw = CTRL_RESET;
    hw(1'b0, cw, 30);
    chk_cw(cw);
    hr(1'b0, 24);
    chk("ctrl read", rd, cw);
    $display("t_fields done");
  endtask
  task automatic t_coef;
    wr_cw(MODE_ZS_ACCESS, 1'b0);
    hw(1'b1, 24'h123456, 24);
    hw(1'b1, 24'hfedcba, 20);
    hr(1'b1, 24);
    chk("zero coef", rd, 24'h123456);
    wr_cw(MODE_FS_ACCESS, 1'b1);
    hw(1'b1, 24'habcdef, 24);
    hr(1'b1, 24);
    chk("full coef 1", rd, 24'habcdef);
    wr_cw(MODE_FS_ACCESS, 1'b0);
    hr(1'b1, 24);
    chk("full coef 0", rd, FS_RESET);
    $display("t_coef done");
  endtask
  task automatic t_result;
    wr_cw(MODE_NORMAL, 1'b0);
    pulse(24'h5a5a5a, 24'h0, 24'h0);
    wait_ready();
    hr(1'b1, 16);
    chk("result 16", rd, 24'h005a5a);
    chk("ready off", 24'(data_ready_n_out), 24'h1);
    cw.output_word_length_bit = 1'b1;
    wr_cw(MODE_NORMAL, 1'b0);
    pulse(24'hc3c3c3, 24'h0, 24'h0);
    wait_ready();
    hr(1'b1, 24);
    chk("result 24", rd, 24'hc3c3c3);
    cw.output_word_length_bit = 1'b0;
    cw.power_down_bit = 1'b1;
    wr_cw(MODE_NORMAL, 1'b0);
    pulse(24'h1, 24'h0, 24'h0);
    repeat (4) @(posedge sys_clk_in);
    chk("ready pd", 24'(data_ready_n_out), 24'h1);
    cw.power_down_bit = 1'b0;
    $display("t_result done");
  endtask
  task automatic t_offset;
    wr_cw(MODE_SELF, 1'b0);
    pulse(24'h0, 24'h000011, 24'h700000);
    wait_ready();
    chk("self back", 24'(mode_out), 24'(MODE_NORMAL));
    hr(1'b1, 16);
    chk("ready rel", 24'(data_ready_n_out), 24'h1);
    wr_cw(MODE_SYS_OFFSET, 1'b1);
    pulse(24'h000321, 24'h0000aa, 24'h654321);
    wait_ready();
    chk("mode back", 24'(mode_out), 24'(MODE_NORMAL));
    wr_cw(MODE_ZS_ACCESS, 1'b1);
    hr(1'b1, 24);
    chk("offset zero", rd, 24'h000321);
    wr_cw(MODE_FS_ACCESS, 1'b1);
    hr(1'b1, 24);
    chk("offset full", rd, 24'h654321);
    $display("t_offset done");
  endtask
  task automatic t_bg;
    wr_cw(MODE_BACKGROUND, 1'b0);
    hr(1'b1, 16);
    repeat (5) pulse(24'h111111, 24'h000bbb, 24'h777777);
    repeat (2) @(posedge sys_clk_in);
    chk("ready 5", 24'(data_ready_n_out), 24'h1);
    pulse(24'h111111, 24'h000bbb, 24'h777777);
    wait_ready();
    wr_cw(MODE_ZS_ACCESS, 1'b0);
    hr(1'b1, 24);
    chk("bg zero", rd, 24'h000bbb);
    wr_cw(MODE_FS_ACCESS, 1'b0);
    hr(1'b1, 24);
    chk("bg full", rd, 24'h777777);
    $display("t_bg done");
  endtask
  initial begin
    // rising reset also clears the link-side hold flops
    rst_in <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_fields();
    t_coef();
    t_result();
    t_offset();
    t_bg();
    end_of_test();
  end
  initial begin
    #3000000;
    fail_count++;
    $display("[ERR] run watchdog expected end seen hang");
    end_of_test();
  end
endmodule
bind acwd_top acwd_properties acwd_properties_i (.*);
